// ==== core/shi_pkg.sv ====
package shi_pkg;
   localparam int          DW            = 8;
   localparam int          FIFO_DEPTH    = 8;
   // status register field positions
   localparam int          ST_OBF_BIT    = 0;
   localparam int          ST_IBF_BIT    = 1;
   localparam int          ST_FA_BIT     = 2;
   localparam int          ST_FB_BIT     = 3;
   localparam int          ST_USER_LO    = 4;
   localparam logic [7:0]  STATUS_RESET  = 8'h00;
   // interface-related opcodes
   localparam logic [7:0]  OP_LOAD_STS   = 8'h90;
   localparam logic [7:0]  OP_EN_FLAGS   = 8'hF5;
   localparam logic [7:0]  OP_EN_DMA     = 8'hE5;
   localparam logic [7:0]  OP_JMP_IEMPTY = 8'hD6;
   localparam logic [7:0]  OP_JMP_OFULL  = 8'h86;
   localparam logic [7:0]  OP_IN_DBB     = 8'h22;
   localparam logic [7:0]  OP_OUT_DBB    = 8'h02;
   localparam logic [10:0] PC_RESET      = 11'h000;
   localparam logic [10:0] PC_STEP2      = 11'h002;
   localparam logic [10:0] PC_STEP1      = 11'h001;

   typedef struct packed {
      logic       cs_n;
      logic       rd_n;
      logic       wr_n;
      logic       reg_sel;
      logic [7:0] data;
   } shi_host_bus_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] opcode;
      logic [7:0] acc;
      logic [7:0] target;
   } shi_cpu_op_t;
endpackage : shi_pkg

// ==== core/shi_fifo.sv ====
`timescale 1ns/10ps
module shi_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             i_clk,
   input  wire logic             i_rstn,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic      [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wp_r;
   logic [AW:0]      wp_nxt;
   logic [AW:0]      rp_r;
   logic [AW:0]      rp_nxt;
   logic             push;
   logic             pop;

   always_comb
   begin
      o_out_valid = (wp_r != rp_r);
      o_in_ready  = ~((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
      push        = i_in_valid & o_in_ready;
      pop         = o_out_valid & i_out_ready;
      wp_nxt      = push ? wp_r + 1'b1 : wp_r;
      rp_nxt      = pop ? rp_r + 1'b1 : rp_r;
      o_out_data  = mem[rp_r[AW-1:0]];
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         wp_r <= '0;
         rp_r <= '0;
      end
      else
      begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
      end
   end

   // storage has no reset; valid words are tracked by the pointers
   always_ff @(posedge i_clk)
   begin
      if (push)
      begin
         mem[wp_r[AW-1:0]] <= i_in_data;
      end
   end
endmodule : shi_fifo

// ==== core/shi_edge.sv ====
`timescale 1ns/10ps
module shi_edge (
   input  wire logic i_clk,
   input  wire logic i_rstn,
   input  wire logic i_strobe_n,
   output logic      o_rise
);
   logic prev_r;
   logic prev_nxt;

   always_comb
   begin
      prev_nxt = i_strobe_n;
      o_rise   = i_strobe_n & ~prev_r;
   end

   // idle level of the strobe is high, so reset does not fake an edge
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         prev_r <= 1'b1;
      end
      else
      begin
         prev_r <= prev_nxt;
      end
   end
endmodule : shi_edge

// ==== core/shi_host_port.sv ====
`timescale 1ns/10ps
module shi_host_port (
   input  wire logic                  i_clk,
   input  wire logic                  i_rstn,
   input  wire shi_pkg::shi_host_bus_t i_host,
   output logic [7:0]                 o_host_data,
   output logic                       o_host_data_oe,
   input  wire shi_pkg::shi_cpu_op_t  i_op,
   input  wire logic                  i_wr_port_four,
   input  wire logic                  i_wr_port_five,
   input  wire logic                  i_wr_port_six,
   input  wire logic [2:0]            i_port_wdata,
   input  wire logic                  i_set_flag_a,
   input  wire logic                  i_clr_flag_a,
   input  wire logic                  i_dma_acknowledge,
   input  wire logic                  i_in_ready,
   output logic                       o_in_valid,
   output logic [7:0]                 o_in_data,
   output logic [7:0]                 o_acc_load,
   output logic                       o_acc_load_valid,
   output logic [10:0]                o_pc,
   output logic                       o_port_line_four,
   output logic                       o_port_line_five,
   output logic                       o_port_line_six,
   output logic [7:0]                 o_host_status,
   output logic                       o_flags_enabled,
   output logic                       o_dma_enabled,
   output logic                       o_fifo_ready
);
   logic [7:0]  in_buf_r,    in_buf_nxt;
   logic [7:0]  out_buf_r,   out_buf_nxt;
   logic [7:0]  status_r,    status_nxt;
   logic        flags_en_r,  flags_en_nxt;
   logic        dma_en_r,    dma_en_nxt;
   logic        p4_r,        p4_nxt;
   logic        p5_r,        p5_nxt;
   logic        p6_r,        p6_nxt;
   logic        dreq_r,      dreq_nxt;
   logic [10:0] pc_r,        pc_nxt;
   logic [7:0]  dout_r,      dout_nxt;
   logic        doe_r,       doe_nxt;
   logic [7:0]  acc_r,       acc_nxt;
   logic        accv_r,      accv_nxt;
   logic [7:0]  wlat_r,      wlat_nxt;
   logic        alat_r,      alat_nxt;
   logic        rsel_r,      rsel_nxt;
   logic        dsel_r,      dsel_nxt;
   logic        ack_r,       ack_nxt;
   logic        rd_rise;
   logic        wr_rise;
   logic        sel;
   logic        sel_buf;
   logic        op_is;
   logic        fifo_in_ready;
   logic        fifo_out_valid;
   logic [7:0]  fifo_out_data;
   logic        fifo_pop;
   // i_in_ready is left unread: the input side is one buffer with no queue

   // trailing-edge detectors, one per strobe
   shi_edge u_rd_edge (
      .i_clk      (i_clk),
      .i_rstn     (i_rstn),
      .i_strobe_n (i_host.rd_n),
      .o_rise     (rd_rise)
   );

   shi_edge u_wr_edge (
      .i_clk      (i_clk),
      .i_rstn     (i_rstn),
      .i_strobe_n (i_host.wr_n),
      .o_rise     (wr_rise)
   );

   // outbound words queue here so firmware can run ahead of the host
   shi_fifo #(
      .WIDTH (shi_pkg::DW),
      .DEPTH (shi_pkg::FIFO_DEPTH)
   ) u_out_fifo (
      .i_clk       (i_clk),
      .i_rstn      (i_rstn),
      .i_in_valid  (i_op.valid && i_op.opcode == shi_pkg::OP_OUT_DBB),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   (i_op.acc),
      .o_out_valid (fifo_out_valid),
      .i_out_ready (fifo_pop),
      .o_out_data  (fifo_out_data)
   );

   always_comb
   begin
      // address and select are sampled while a strobe is low and held after it; the trailing edge acts
      sel      = ~i_host.cs_n | (dma_en_r & i_dma_acknowledge);
      sel_buf  = dma_en_r & i_dma_acknowledge;
      rsel_nxt = (~i_host.rd_n | ~i_host.wr_n) ? i_host.reg_sel & ~sel_buf : rsel_r;
      dsel_nxt = (~i_host.rd_n | ~i_host.wr_n) ? sel : dsel_r;
      ack_nxt  = (~i_host.rd_n | ~i_host.wr_n) ? sel_buf : ack_r;
      wlat_nxt = ~i_host.wr_n ? i_host.data : wlat_r;
      // flag a waits here and reaches the status only when a strobe ends
      alat_nxt = alat_r;
      in_buf_nxt   = in_buf_r;
      out_buf_nxt  = out_buf_r;
      status_nxt   = status_r;
      flags_en_nxt = flags_en_r;
      dma_en_nxt   = dma_en_r;
      p4_nxt       = p4_r;
      p5_nxt       = p5_r;
      p6_nxt       = p6_r;
      dreq_nxt     = dreq_r;
      pc_nxt       = pc_r;
      acc_nxt      = acc_r;
      // accumulator load is a one-cycle pulse
      accv_nxt     = 1'b0;
      fifo_pop     = 1'b0;
      op_is        = i_op.valid;
      // host output register: drive while a selected read strobe is low
      doe_nxt  = ~i_host.rd_n & sel;
      // acknowledge ignores register select: dma moves data, never status
      dout_nxt = (i_host.reg_sel & ~sel_buf) ? status_r : out_buf_r;
      // refill the output buffer from the queue once the host has taken it
      // a refill beside a host read of the empty buffer keeps its flag
      if (!status_r[shi_pkg::ST_OBF_BIT] && fifo_out_valid)
      begin
         out_buf_nxt = fifo_out_data;
         status_nxt[shi_pkg::ST_OBF_BIT] = 1'b1;
         fifo_pop = 1'b1;
      end
      if (op_is)
      begin
         pc_nxt = pc_r + shi_pkg::PC_STEP1;
         case (i_op.opcode)
            shi_pkg::OP_LOAD_STS:
            begin
               status_nxt[7:shi_pkg::ST_USER_LO] = i_op.acc[7:4];
            end
            shi_pkg::OP_EN_FLAGS:
            begin
               flags_en_nxt = 1'b1;
            end
            shi_pkg::OP_EN_DMA:
            begin
               dma_en_nxt = 1'b1;
               dreq_nxt   = 1'b0;
            end
            shi_pkg::OP_IN_DBB:
            begin
               acc_nxt  = in_buf_r;
               accv_nxt = 1'b1;
               status_nxt[shi_pkg::ST_IBF_BIT] = 1'b0;
            end
            // a taken jump stays inside the current 256-word page; the not-taken skip adds 2 to the pc and can cross it
            shi_pkg::OP_JMP_IEMPTY:
            begin
               pc_nxt = !status_r[shi_pkg::ST_IBF_BIT] ? {pc_r[10:8], i_op.target}
                                                       : pc_r + shi_pkg::PC_STEP2;
            end
            shi_pkg::OP_JMP_OFULL:
            begin
               pc_nxt = status_r[shi_pkg::ST_OBF_BIT] ? {pc_r[10:8], i_op.target}
                                                      : pc_r + shi_pkg::PC_STEP2;
            end
            default:
            begin
               pc_nxt = pc_r + shi_pkg::PC_STEP1;
            end
         endcase
      end
      if (i_set_flag_a)
      begin
         alat_nxt = 1'b1;
      end
      else if (i_clr_flag_a)
      begin
         alat_nxt = 1'b0;
      end
      if (i_wr_port_four)
      begin
         p4_nxt = i_port_wdata[0];
      end
      if (i_wr_port_five)
      begin
         p5_nxt = i_port_wdata[1];
      end
      // trailing-edge flag updates; host events win over firmware clears
      if (rd_rise && dsel_r)
      begin
         status_nxt[shi_pkg::ST_FA_BIT] = alat_r;
         if (!rsel_r && !fifo_pop)
         begin
            status_nxt[shi_pkg::ST_OBF_BIT] = 1'b0;
         end
         if (ack_r)
         begin
            dreq_nxt = 1'b0;
         end
      end
      if (wr_rise && dsel_r)
      begin
         in_buf_nxt = wlat_r;
         status_nxt[shi_pkg::ST_IBF_BIT] = 1'b1;
         status_nxt[shi_pkg::ST_FB_BIT]  = rsel_r;
         status_nxt[shi_pkg::ST_FA_BIT]  = alat_r;
         if (ack_r)
         begin
            dreq_nxt = 1'b0;
         end
      end
      // a new firmware request wins over a clear by acknowledge in one cycle
      if (i_wr_port_six)
      begin
         p6_nxt = i_port_wdata[2];
         if (dma_en_r && i_port_wdata[2])
         begin
            dreq_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         in_buf_r   <= 8'h00;
         out_buf_r  <= 8'h00;
         status_r   <= shi_pkg::STATUS_RESET;
         flags_en_r <= 1'b0;
         dma_en_r   <= 1'b0;
         // port lines idle high until firmware writes them
         p4_r       <= 1'b1;
         p5_r       <= 1'b1;
         p6_r       <= 1'b1;
         dreq_r     <= 1'b0;
         pc_r       <= shi_pkg::PC_RESET;
         dout_r     <= 8'h00;
         doe_r      <= 1'b0;
         acc_r      <= 8'h00;
         accv_r     <= 1'b0;
         wlat_r     <= 8'h00;
         alat_r     <= 1'b0;
         rsel_r     <= 1'b0;
         dsel_r     <= 1'b0;
         ack_r      <= 1'b0;
      end
      else
      begin
         in_buf_r   <= in_buf_nxt;
         out_buf_r  <= out_buf_nxt;
         status_r   <= status_nxt;
         flags_en_r <= flags_en_nxt;
         dma_en_r   <= dma_en_nxt;
         p4_r       <= p4_nxt;
         p5_r       <= p5_nxt;
         p6_r       <= p6_nxt;
         dreq_r     <= dreq_nxt;
         pc_r       <= pc_nxt;
         dout_r     <= dout_nxt;
         doe_r      <= doe_nxt;
         acc_r      <= acc_nxt;
         accv_r     <= accv_nxt;
         wlat_r     <= wlat_nxt;
         alat_r     <= alat_nxt;
         rsel_r     <= rsel_nxt;
         dsel_r     <= dsel_nxt;
         ack_r      <= ack_nxt;
      end
   end

   // pin muxes, registered so each pin leaves a flip-flop
   logic pin4_r;
   logic pin5_r;
   logic pin6_r;
   logic inv_r;
   logic fr_r;
   logic pin4_nxt;
   logic pin5_nxt;
   logic pin6_nxt;
   logic inv_nxt;
   logic fr_nxt;

   always_comb
   begin
      // pins take next-state values so they move with the status register
      pin4_nxt = flags_en_nxt ? (p4_nxt & status_nxt[shi_pkg::ST_OBF_BIT]) : p4_nxt;
      pin5_nxt = flags_en_nxt ? (p5_nxt & status_nxt[shi_pkg::ST_IBF_BIT]) : p5_nxt;
      pin6_nxt = dma_en_nxt ? dreq_nxt : p6_nxt;
      inv_nxt  = accv_nxt;
      fr_nxt   = fifo_in_ready;
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         pin4_r <= 1'b1;
         pin5_r <= 1'b1;
         pin6_r <= 1'b1;
         inv_r  <= 1'b0;
         fr_r   <= 1'b0;
      end
      else
      begin
         pin4_r <= pin4_nxt;
         pin5_r <= pin5_nxt;
         pin6_r <= pin6_nxt;
         inv_r  <= inv_nxt;
         fr_r   <= fr_nxt;
      end
   end

   // every output below is a plain flip-flop
   assign o_host_data      = dout_r;
   assign o_host_data_oe   = doe_r;
   assign o_in_valid       = inv_r;
   assign o_in_data        = acc_r;
   assign o_acc_load       = acc_r;
   assign o_acc_load_valid = accv_r;
   assign o_pc             = pc_r;
   assign o_port_line_four = pin4_r;
   assign o_port_line_five = pin5_r;
   assign o_port_line_six  = pin6_r;
   assign o_host_status    = status_r;
   assign o_flags_enabled  = flags_en_r;
   assign o_dma_enabled    = dma_en_r;
   assign o_fifo_ready     = fr_r;
endmodule : shi_host_port

// ==== bench/shi_host_port_monitor.sv ====
`timescale 1ns/10ps
module shi_check (
   input wire logic                   i_clk,
   input wire logic                   i_rstn,
   input wire shi_pkg::shi_host_bus_t i_host,
   input wire shi_pkg::shi_cpu_op_t   i_op,
   input wire logic                   i_dma_acknowledge,
   input wire logic [10:0]            o_pc,
   input wire logic                   o_port_line_six,
   input wire logic [7:0]             o_host_status,
   input wire logic                   o_dma_enabled
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rstn);

   ibf_cause_a: assert property ($rose(o_host_status[1]) |->
      !$past(i_host.wr_n, 2) || !$past(i_host.wr_n, 3) || !$past(i_host.wr_n, 4))
      else $error("input full rose without a write");
   obf_cause_a: assert property ($fell(o_host_status[0]) |->
      !$past(i_host.rd_n, 2) || !$past(i_host.rd_n, 3) || !$past(i_host.rd_n, 4))
      else $error("output full fell without a read");
   strobe_hold_a: assert property (!i_host.wr_n && !$past(i_host.wr_n) |->
      $stable(o_host_status[3:2])) else $error("flags moved mid strobe");
   nibble_load_a: assert property (i_op.valid && i_op.opcode == shi_pkg::OP_LOAD_STS |=>
      o_host_status == {$past(i_op.acc[7:4]), $past(o_host_status[3:0])}) else $error("status nibble");
   jump_empty_a: assert property (i_op.valid && i_op.opcode == shi_pkg::OP_JMP_IEMPTY |=>
      o_pc == ($past(o_host_status[1]) ? $past(o_pc) + 11'h002 : {$past(o_pc[10:8]), $past(i_op.target)}))
      else $error("jump on input empty");
   jump_full_a: assert property (i_op.valid && i_op.opcode == shi_pkg::OP_JMP_OFULL |=>
      o_pc == ($past(o_host_status[0]) ? {$past(o_pc[10:8]), $past(i_op.target)} : $past(o_pc) + 11'h002))
      else $error("jump on output full");
   dma_op_drop_a: assert property (i_op.valid && i_op.opcode == shi_pkg::OP_EN_DMA |->
      ##[1:3] !o_port_line_six) else $error("request kept after dma enable");
   ack_drop_a: assert property (o_dma_enabled && i_dma_acknowledge && $rose(i_host.rd_n) |->
      ##[1:4] !o_port_line_six) else $error("request kept after acknowledged read");

   ibf_seen_c: cover property ($rose(o_host_status[1]));
   dma_read_c: cover property (i_dma_acknowledge && !i_host.rd_n);
   nibble_c: cover property (i_op.valid && i_op.opcode == shi_pkg::OP_LOAD_STS);
endmodule : shi_check

bind shi_host_port shi_check u_chk (.i_clk, .i_rstn, .i_host, .i_op, .i_dma_acknowledge, .o_pc,
   .o_port_line_six, .o_host_status, .o_dma_enabled);

// ==== bench/shi_host_model.sv ====
`timescale 1ns/10ps
module shi_host_model (
   input  wire logic              i_clk,
   input  wire logic [7:0]        i_data,
   input  wire logic              i_oe,
   output shi_pkg::shi_host_bus_t o_host,
   output logic                   o_ack
);
   initial o_host = 12'hE00;
   initial o_ack = 1'b0;

   // strobe held three cycles; read data taken before the strobe rises
   task xfer(input logic wr, dma, rs, input logic [7:0] d, output logic [7:0] q);
      // plain transfers select by chip select, dma transfers by acknowledge alone
      @(negedge i_clk) o_host = {dma, wr, ~wr, rs, d};
      o_ack = dma;
      repeat (3) @(negedge i_clk);
      q = i_oe ? i_data : ~i_data;
      o_host.rd_n = 1'b1;
      o_host.wr_n = 1'b1;
      // released bus no longer shows the last byte
      @(negedge i_clk) o_host = {3'h7, rs, ~d};
      o_ack = 1'b0;
      repeat (3) @(negedge i_clk);
   endtask : xfer
endmodule : shi_host_model

// ==== bench/shi_host_port_bench.sv ====
`timescale 1ns/10ps
module shi_host_port_bench;
   logic                   clk  = 1'b0;
   logic                   rstn = 1'b0;
   shi_pkg::shi_host_bus_t host;
   shi_pkg::shi_cpu_op_t   op   = '0;
   logic [2:0]             wp   = 3'h0;
   logic [2:0]             pwd  = 3'h0;
   logic                   sfa  = 1'b0;
   logic                   cfa  = 1'b0;
   logic                   ack, oe, accv, inv, flen, dmen, frdy, p4, p5, p6;
   logic [7:0]             hd, accl, ind, li, st, q, ld;
   logic [10:0]            pc, p;
   int                     error_cnt = 0;
   int                     samples_checked = 0;
   int                     cyc = 0;

   shi_host_port uut (.i_clk(clk), .i_rstn(rstn), .i_host(host), .o_host_data(hd), .o_host_data_oe(oe),
      .i_op(op), .i_wr_port_four(wp[0]), .i_wr_port_five(wp[1]), .i_wr_port_six(wp[2]), .i_port_wdata(pwd),
      .i_set_flag_a(sfa), .i_clr_flag_a(cfa), .i_dma_acknowledge(ack), .i_in_ready(1'b1), .o_in_valid(inv),
      .o_in_data(ind), .o_acc_load(accl), .o_acc_load_valid(accv), .o_pc(pc), .o_port_line_four(p4),
      .o_port_line_five(p5), .o_port_line_six(p6), .o_host_status(st), .o_flags_enabled(flen),
      .o_dma_enabled(dmen), .o_fifo_ready(frdy));
   shi_host_model hm (.i_clk(clk), .i_data(hd), .i_oe(oe), .o_host(host), .o_ack(ack));

   always #5 clk = ~clk;
   always @(posedge clk) if (accv) ld <= accl;
   always @(posedge clk) if (inv) li <= ind;
   always @(posedge clk) cyc <= cyc + 1;
   always @(posedge clk) if (cyc == 3000) wrap_up(1'b1);

   task wrap_up(input logic late);
      if (late) error_cnt++;
      $display("checked %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : wrap_up

   task chk(input string n, input logic [10:0] e, g);
      samples_checked++;
      if (g !== e) error_cnt++;
      if (g !== e) $display("ERROR %s expected %h seen %h", n, e, g);
   endtask : chk

   task fw(input logic [7:0] c, a, t);
      @(negedge clk) op = {1'b1, c, a, t};
      @(negedge clk) op.valid = 1'b0;
      repeat (3) @(negedge clk);
   endtask : fw

   task pw(input int n, input logic v);
      @(negedge clk) wp[n] = 1'b1;
      pwd[n] = v;
      @(negedge clk) wp = 3'h0;
      repeat (3) @(negedge clk);
   endtask : pw

   task wr(input logic rs, input logic [7:0] d);
      hm.xfer(1'b1, 1'b0, rs, d, q);
   endtask : wr

   task rd(input logic rs);
      hm.xfer(1'b0, 1'b0, rs, 8'h00, q);
   endtask : rd

   // refill from the queue takes a few cycles, pins move with the flag; three more cycles follow
   task wait_obf;
      for (int n = 0; n < 40 && st[0] !== 1'b1; n++) @(negedge clk);
      repeat (3) @(negedge clk);
   endtask : wait_obf

   task t_reset;
      chk("status", 8'h00, st);
      chk("pins", 3'h7, {p6, p5, p4});
      chk("oe", 1'b0, oe);
      chk("pc", 11'h000, pc);
   endtask : t_reset

   task t_input;
      fw(shi_pkg::OP_JMP_IEMPTY, 8'h00, 8'h40);
      chk("pc", 11'h040, pc);
      @(negedge clk) sfa = 1'b1;
      @(negedge clk) sfa = 1'b0;
      chk("flag_a", 1'b0, st[2]);
      wr(1'b1, 8'h5A);
      chk("status", 4'hE, st[3:0]);
      fw(shi_pkg::OP_JMP_IEMPTY, 8'h00, 8'h80);
      chk("pc", 11'h042, pc);
      fw(shi_pkg::OP_IN_DBB, 8'h00, 8'h00);
      chk("in_data", 8'h5A, ld);
      chk("ibf", 1'b0, st[1]);
      wr(1'b0, 8'hA5);
      chk("flag_b", 1'b0, st[3]);
      fw(shi_pkg::OP_IN_DBB, 8'h00, 8'h00);
      chk("in_data", 8'hA5, ld);
      chk("in_valid_data", 8'hA5, li);
   endtask : t_input

   task t_output;
      p = pc;
      fw(shi_pkg::OP_JMP_OFULL, 8'h00, 8'h10);
      chk("pc", p + 11'h002, pc);
      fw(shi_pkg::OP_OUT_DBB, 8'hC3, 8'h00);
      wait_obf;
      p = pc;
      fw(shi_pkg::OP_JMP_OFULL, 8'h00, 8'h10);
      chk("pc", {p[10:8], 8'h10}, pc);
      rd(1'b1);
      chk("status", 8'h05, q);
      rd(1'b0);
      chk("out_data", 8'hC3, q);
      chk("obf", 1'b0, st[0]);
   endtask : t_output

   // nine words fit (one buffer, eight queued); the tenth is dropped
   task t_fifo;
      for (int i = 0; i < 10; i++) fw(shi_pkg::OP_OUT_DBB, 8'(i), 8'h00);
      chk("fifo_ready", 1'b0, frdy);
      for (int i = 0; i < 9; i++)
      begin
         wait_obf;
         rd(1'b0);
         chk("out_data", 11'(i), q);
      end
      chk("obf", 1'b0, st[0]);
   endtask : t_fifo

   task t_nibble;
      fw(shi_pkg::OP_LOAD_STS, 8'hA5, 8'h00);
      chk("status", 8'hA4, st);
      @(negedge clk) cfa = 1'b1;
      @(negedge clk) cfa = 1'b0;
      wr(1'b0, 8'h3C);
      chk("flag_a", 1'b0, st[2]);
      fw(shi_pkg::OP_IN_DBB, 8'h00, 8'h00);
      chk("in_data", 8'h3C, ld);
   endtask : t_nibble

   task t_flags;
      fw(shi_pkg::OP_EN_FLAGS, 8'h00, 8'h00);
      chk("flags_on", 1'b1, flen);
      pw(0, 1'b1);
      chk("pin_four", 1'b0, p4);
      fw(shi_pkg::OP_OUT_DBB, 8'h11, 8'h00);
      wait_obf;
      chk("pin_four", 1'b1, p4);
      pw(0, 1'b0);
      chk("pin_four", 1'b0, p4);
      pw(1, 1'b1);
      wr(1'b0, 8'h22);
      chk("pin_five", 1'b1, p5);
      fw(shi_pkg::OP_IN_DBB, 8'h00, 8'h00);
      chk("pin_five", 1'b0, p5);
   endtask : t_flags

   // acknowledge replaces chip select and ignores register select
   task t_dma;
      fw(shi_pkg::OP_EN_DMA, 8'h00, 8'h00);
      chk("dma_on", 1'b1, dmen);
      chk("request", 1'b0, p6);
      pw(2, 1'b1);
      chk("request", 1'b1, p6);
      hm.xfer(1'b0, 1'b1, 1'b1, 8'h00, q);
      chk("dma_data", 8'h11, q);
      chk("request", 1'b0, p6);
      hm.xfer(1'b1, 1'b1, 1'b0, 8'h77, q);
      chk("ibf", 1'b1, st[1]);
   endtask : t_dma

   initial
   begin
      repeat (16) @(negedge clk);
      rstn = 1'b1;
      t_reset;
      t_input;
      t_output;
      t_fifo;
      t_nibble;
      t_flags;
      t_dma;
      wrap_up(1'b0);
   end
endmodule : shi_host_port_bench
